// ===== rtl/relay_pkg.sv
// Shared constants for the relay logic-input functions block.
// Assumes a single 50 MHz clock and AXI4-Lite software access.
`default_nettype none

package relay_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam int ADDR_W = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_MON_EN = 0;
  localparam int CTRL_GRP_MAP1 = 1;
  localparam int CTRL_GRP_MAP2 = 2;
  localparam int CTRL_FLT_MAP = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Supervision alarm delay in milliseconds
  localparam int DELAY_W = 16;
  localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0064;

  // Interrupt status and mask fields
  localparam int IRQ_W = 5;
  localparam int IRQ_CLOSE = 0;
  localparam int IRQ_BLOCKED = 1;
  localparam int IRQ_TRIP = 2;
  localparam int IRQ_ALARM = 3;
  localparam int IRQ_GROUP = 4;

  // Status register fields
  localparam int STAT_GROUP = 0;
  localparam int STAT_CLOSE = 1;
  localparam int STAT_TRIP = 2;
  localparam int STAT_ALARM = 3;
  localparam int STAT_SUP = 4;
  localparam int STAT_IN_LSB = 8;

  // Synchronised input vector positions
  localparam int IN_W = 5;
  localparam int IN_GROUP = 0;
  localparam int IN_CLOSE = 1;
  localparam int IN_TRIP = 2;
  localparam int IN_FAULT = 3;
  localparam int IN_TCS = 4;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 16;
endpackage : relay_pkg

`default_nettype wire

// ===== rtl/supervision_if.sv
// Link between the block core and its supervision delay timer.
// Assumes both ends share one clock.
`default_nettype none

interface supervision_if;
  import relay_pkg::*;
  logic run;
  logic [DELAY_W-1:0] delay;
  logic done;
  modport ctrl (output run, output delay, input done);
  modport timer (input run, input delay, output done);
endinterface : supervision_if

`default_nettype wire

// ===== rtl/pin_sync.sv
// Two-stage synchroniser for the binary contact inputs.
// Assumes the pins are asynchronous levels with no bounce filter needed here.
`default_nettype none

module pin_sync
  import relay_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Pins and synchronised levels
  input wire logic [relay_pkg::IN_W-1:0] pins_in,
  output logic [relay_pkg::IN_W-1:0] levels_out
);
  import relay_pkg::*;

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  // First stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign levels_out = st_reg.s2;

  // Only judged once both stages have left reset, else the reset zeros look like a loss
  property p_sync_lat;
    @(posedge clk_in) disable iff (!nrst_in)
      $past(nrst_in, 2) |-> (levels_out == $past(pins_in, 2));
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("input level not passed through two stages");
endmodule : pin_sync

`default_nettype wire

// ===== rtl/alarm_delay_timer.sv
// Millisecond delay timer for trip-circuit supervision.
// Assumes run stays high for as long as the fault condition lasts.
`default_nettype none

module alarm_delay_timer
  import relay_pkg::*;
#(
  parameter int unsigned TICKS = relay_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Timer link
  supervision_if.timer sup
);
  import relay_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [DELAY_W-1:0] ms;
    logic done;
  } timer_t;

  timer_t st_reg;
  timer_t st_next;

  // Counting restarts whenever run drops, so a short blip never accumulates
  always_comb begin
    st_next = st_reg;
    if (!sup.run) begin
      st_next = '0;
    end else if (st_reg.ms == sup.delay) begin
      st_next.done = 1'h1;
    end else if (st_reg.div == DIV_W'(TICKS - 1)) begin
      st_next.div = '0;
      st_next.ms = st_reg.ms + DELAY_W'(1);
    end else begin
      st_next.div = st_reg.div + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sup.done = st_reg.done;

  property p_done_at_delay;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(sup.done) |-> ($past(st_reg.ms) == $past(sup.delay)) && $past(sup.run);
  endproperty
  a_done_at_delay: assert property (p_done_at_delay)
    else $error("alarm delay ended before the set time");
endmodule : alarm_delay_timer

`default_nettype wire

// ===== rtl/relay_logic_input_functions.sv
// Binary logic-input functions: group select, manual close and trip, trip-circuit
// supervision, with an AXI4-Lite register slave and a level interrupt.
// Assumes one 50 MHz clock; contact pins are asynchronous, the protection trip and
// latched-LED flags come from logic on the same clock.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`default_nettype none

// Operation
// - Group select input low selects setting group one.
// - Group select input high selects setting group two.
// - Group follows the input only when mapped in both groups.
// - Accepted manual close drives the breaker close output.
// - Manual close activation also starts switch onto fault.
// - Manual close is blocked while any front indicator stays latched.
// - Manual close is blocked while mapped external breaker fault is high.
// - Manual trip input drives the breaker trip output.
// - Trip circuit continuity is watched whatever the breaker position.
// - Supervision evaluates only while no trip output is asserted.
// - Supervision and its alarm work only when enabled.
// - Alarm asserts only after fault persists for the set delay.
module relay_logic_input_functions
  import relay_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // AXI4-Lite write channels
  input wire logic [relay_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [relay_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Binary contact inputs
  input wire logic group_select_in,
  input wire logic manual_close_in,
  input wire logic manual_trip_in,
  input wire logic breaker_fault_external_signal_in,
  input wire logic trip_circuit_in,
  // Same-clock flags
  input wire logic protection_trip_in,
  input wire logic leds_latched_in,
  // Relay outputs
  output logic breaker_close_output_out,
  output logic breaker_trip_output_out,
  output logic breaker_alarm_output_out,
  output logic switch_onto_fault_out,
  output logic active_group_out,
  output logic irq_out
);
  import relay_pkg::*;

  typedef struct packed {
    logic grp;
    logic close;
    logic trip;
    logic onto_pulse;
    logic alarm;
    logic req_q;
    logic [CTRL_W-1:0] ctrl;
    logic [DELAY_W-1:0] delay;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } core_t;

  localparam core_t CORE_RST = '{ctrl: CTRL_RST, delay: DELAY_RST, default: '0};

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Address decode shared by the read and write paths
  function automatic logic [1:0] resp_of(input logic [ADDR_W-1:0] a);
    logic [1:0] r;
    r = RESP_SLVERR;
    if (a == OFF_CTRL || a == OFF_DELAY || a == OFF_STATUS || a == OFF_IRQ_STAT ||
        a == OFF_IRQ_MASK) begin
      r = RESP_OKAY;
    end
    return r;
  endfunction

  core_t st_reg;
  core_t st_next;
  logic [IN_W-1:0] in_s;
  logic wr_go;
  logic rd_go;
  logic close_req;
  logic close_blocked;
  logic sup_active;
  logic tcs_fault;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c;
  logic [31:0] status_word;

  supervision_if sup ();

  // Contact inputs pass two flops before any function looks at them
  pin_sync u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .pins_in({trip_circuit_in, breaker_fault_external_signal_in, manual_trip_in,
              manual_close_in, group_select_in}),
    .levels_out(in_s)
  );

  alarm_delay_timer #(
    .TICKS(TICKS)
  ) u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sup(sup)
  );

  // Bus handshakes: address and data are taken together, one transfer at a time
  assign wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !st_reg.bvalid;
  assign rd_go = s_axi_arvalid_in && !st_reg.rvalid;
  assign s_axi_awready_out = wr_go;
  assign s_axi_wready_out = wr_go;
  assign s_axi_arready_out = !st_reg.rvalid;

  // Close blocking conditions and supervision qualifiers
  assign close_req = in_s[IN_CLOSE];
  assign close_blocked = leds_latched_in ||
                         (st_reg.ctrl[CTRL_FLT_MAP] && in_s[IN_FAULT]);
  assign sup_active = !protection_trip_in && !st_reg.trip;
  assign tcs_fault = !in_s[IN_TCS];
  assign sup.run = st_reg.ctrl[CTRL_MON_EN] && sup_active && tcs_fault;
  assign sup.delay = st_reg.delay;
  assign w1c = IRQ_W'(merge(32'h0, s_axi_wdata_in, s_axi_wstrb_in));

  // Read-only view of the block's live state
  always_comb begin
    status_word = '0;
    status_word[STAT_GROUP] = st_reg.grp;
    status_word[STAT_CLOSE] = st_reg.close;
    status_word[STAT_TRIP] = st_reg.trip;
    status_word[STAT_ALARM] = st_reg.alarm;
    status_word[STAT_SUP] = sup_active;
    status_word[STAT_IN_LSB +: IN_W] = in_s;
  end

  // Function logic, interrupt flags and register file
  always_comb begin
    st_next = st_reg;
    events = '0;
    // A half-mapped selector leaves the group where it is
    if (st_reg.ctrl[CTRL_GRP_MAP1] && st_reg.ctrl[CTRL_GRP_MAP2]) begin
      st_next.grp = in_s[IN_GROUP];
    end
    st_next.close = close_req && !close_blocked;
    st_next.onto_pulse = st_next.close && !st_reg.close;
    st_next.req_q = close_req;
    st_next.trip = in_s[IN_TRIP];
    st_next.alarm = sup.done && sup.run;
    events[IRQ_CLOSE] = st_next.onto_pulse;
    events[IRQ_BLOCKED] = close_req && !st_reg.req_q && close_blocked;
    events[IRQ_TRIP] = st_next.trip && !st_reg.trip;
    events[IRQ_ALARM] = st_next.alarm && !st_reg.alarm;
    events[IRQ_GROUP] = st_next.grp != st_reg.grp;
    // Write path
    if (st_reg.bvalid && s_axi_bready_in) begin
      st_next.bvalid = 1'h0;
    end
    if (wr_go) begin
      st_next.bvalid = 1'h1;
      st_next.bresp = resp_of(s_axi_awaddr_in);
      case (s_axi_awaddr_in)
        OFF_CTRL: st_next.ctrl = CTRL_W'(merge(32'(st_reg.ctrl), s_axi_wdata_in,
                                               s_axi_wstrb_in));
        OFF_DELAY: st_next.delay = DELAY_W'(merge(32'(st_reg.delay), s_axi_wdata_in,
                                                  s_axi_wstrb_in));
        OFF_IRQ_STAT: st_next.stat = st_reg.stat & ~w1c;
        OFF_IRQ_MASK: st_next.mask = IRQ_W'(merge(32'(st_reg.mask), s_axi_wdata_in,
                                                  s_axi_wstrb_in));
        default: st_next.stat = st_reg.stat;
      endcase
    end
    // New events win over a clear in the same cycle
    st_next.stat = st_next.stat | events;
    // Read path
    if (st_reg.rvalid && s_axi_rready_in) begin
      st_next.rvalid = 1'h0;
    end
    if (rd_go) begin
      st_next.rvalid = 1'h1;
      st_next.rresp = resp_of(s_axi_araddr_in);
      case (s_axi_araddr_in)
        OFF_CTRL: st_next.rdata = 32'(st_reg.ctrl);
        OFF_DELAY: st_next.rdata = 32'(st_reg.delay);
        OFF_STATUS: st_next.rdata = status_word;
        OFF_IRQ_STAT: st_next.rdata = 32'(st_reg.stat);
        OFF_IRQ_MASK: st_next.rdata = 32'(st_reg.mask);
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops, except irq_out, the OR of the masked status flags
  assign breaker_close_output_out = st_reg.close;
  assign breaker_trip_output_out = st_reg.trip;
  assign breaker_alarm_output_out = st_reg.alarm;
  assign switch_onto_fault_out = st_reg.onto_pulse;
  assign active_group_out = st_reg.grp;
  assign irq_out = |(st_reg.stat & st_reg.mask);
  assign s_axi_bvalid_out = st_reg.bvalid;
  assign s_axi_bresp_out = st_reg.bresp;
  assign s_axi_rvalid_out = st_reg.rvalid;
  assign s_axi_rresp_out = st_reg.rresp;
  assign s_axi_rdata_out = st_reg.rdata;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_close_start;
    !breaker_close_output_out ##1 breaker_close_output_out;
  endsequence

  property p_group_one;
    (st_reg.ctrl[CTRL_GRP_MAP1] && st_reg.ctrl[CTRL_GRP_MAP2] && !in_s[IN_GROUP])
      |=> !active_group_out;
  endproperty
  a_group_one: assert property (p_group_one)
    else $error("low selector did not give group one");

  property p_group_two;
    (st_reg.ctrl[CTRL_GRP_MAP1] && st_reg.ctrl[CTRL_GRP_MAP2] && in_s[IN_GROUP])
      |=> active_group_out;
  endproperty
  a_group_two: assert property (p_group_two)
    else $error("high selector did not give group two");

  property p_group_hold;
    !(st_reg.ctrl[CTRL_GRP_MAP1] && st_reg.ctrl[CTRL_GRP_MAP2]) |=> $stable(active_group_out);
  endproperty
  a_group_hold: assert property (p_group_hold)
    else $error("group changed without mapping in both groups");

  property p_close;
    (close_req && !close_blocked) |=> breaker_close_output_out;
  endproperty
  a_close: assert property (p_close)
    else $error("accepted close did not drive the close output");

  property p_onto_fault;
    s_close_start |-> switch_onto_fault_out ##1 !switch_onto_fault_out [*1];
  endproperty
  a_onto_fault: assert property (p_onto_fault)
    else $error("close start did not pulse switch onto fault");

  property p_led_block;
    leds_latched_in |=> !breaker_close_output_out;
  endproperty
  a_led_block: assert property (p_led_block)
    else $error("close passed while indicators latched");

  property p_fault_block;
    (st_reg.ctrl[CTRL_FLT_MAP] && in_s[IN_FAULT]) |=> !breaker_close_output_out;
  endproperty
  a_fault_block: assert property (p_fault_block)
    else $error("close passed during external breaker fault");

  property p_trip;
    in_s[IN_TRIP] |=> breaker_trip_output_out;
  endproperty
  a_trip: assert property (p_trip)
    else $error("manual trip did not drive the trip output");

  property p_recover;
    (breaker_alarm_output_out && in_s[IN_TCS]) |=> !breaker_alarm_output_out;
  endproperty
  a_recover: assert property (p_recover)
    else $error("alarm stayed with trip circuit healthy");

  property p_no_eval_in_trip;
    (protection_trip_in || breaker_trip_output_out) |=> !breaker_alarm_output_out;
  endproperty
  a_no_eval_in_trip: assert property (p_no_eval_in_trip)
    else $error("supervision alarm during a trip");

  property p_enable;
    !st_reg.ctrl[CTRL_MON_EN] |=> !breaker_alarm_output_out;
  endproperty
  a_enable: assert property (p_enable)
    else $error("alarm raised with supervision disabled");

  property p_alarm_cause;
    $rose(breaker_alarm_output_out) |-> $past(sup.run) && $past(sup.done);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm rose without an expired delay");
endmodule : relay_logic_input_functions

`default_nettype wire

// ===== testbench/breaker_model.sv
// Far-side model: breaker poles and the trip coil circuit.
// Assumes the bench commands coil breaks; the pole follows the relay outputs.
`default_nettype none

module breaker_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Relay commands and bench fault request
  input wire logic close_cmd_in,
  input wire logic trip_cmd_in,
  input wire logic coil_open_in,
  // Coil continuity back to the relay, pole position for the bench
  output logic trip_circuit_out,
  output logic closed_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pole follows the last command; trip wins, as on a real mechanism
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      closed_out <= 1'b0;
    end else if (trip_cmd_in) begin
      closed_out <= 1'b0;
    end else if (close_cmd_in) begin
      closed_out <= 1'b1;
    end
  end
  // Continuity is healthy in either pole position unless a break is asked for
  assign trip_circuit_out = !coil_open_in;
endmodule // breaker_model

`default_nettype wire

// ===== testbench/relay_logic_input_functions_bench.sv
// Self-checking bench for the relay logic-input functions block.
// Assumes TICKS is cut to 4 so alarm delays stay short.
`default_nettype none

module relay_logic_input_functions_bench import relay_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string name; logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} note_t;
  localparam int unsigned TK = 4;
  logic clk_in, nrst_in, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic group_pin, close_pin, trip_pin, fault_pin, coil_open, prot_trip, leds;
  logic close_o, trip_o, alarm_o, onto_o, group_o, irq_o, tc_pin, closed;
  note_t notes[$];
  int err_total, checks, waited, n, p;
  logic [31:0] rnd;

  relay_logic_input_functions #(.TICKS(TK)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .group_select_in(group_pin),
    .manual_close_in(close_pin), .manual_trip_in(trip_pin),
    .breaker_fault_external_signal_in(fault_pin), .trip_circuit_in(tc_pin),
    .protection_trip_in(prot_trip), .leds_latched_in(leds),
    .breaker_close_output_out(close_o), .breaker_trip_output_out(trip_o),
    .breaker_alarm_output_out(alarm_o), .switch_onto_fault_out(onto_o),
    .active_group_out(group_o), .irq_out(irq_o));

  breaker_model far_u (.clk_in(clk_in), .nrst_in(nrst_in), .close_cmd_in(close_o),
    .trip_cmd_in(trip_o), .coil_open_in(coil_open), .trip_circuit_out(tc_pin),
    .closed_out(closed));

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge clk_in);
  endtask

  function automatic logic sig(int s);
    case (s)
      0: return awready;
      1: return bvalid;
      2: return arready;
      3: return rvalid;
      4: return onto_o;
      default: return alarm_o;
    endcase
  endfunction

  // Edges are counted so delays can be judged; a spent bound ends the run
  task automatic await(int s, int lim);
    waited = 0;
    do begin
      @(posedge clk_in);
      waited++;
    end while (sig(s) !== 1'b1 && waited < lim);
    if (sig(s) !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", s);
      close_out();
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] r);
    notes.push_back('{"bresp", 32'h0, 32'h0, r});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    await(0, 50);
    chk("wready", 32'h1, {31'h0, wready});
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    await(1, 50);
    bready <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, logic [1:0] r, string nm);
    notes.push_back('{nm, e, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    await(2, 50);
    arvalid <= 1'b0;
    rready <= 1'b1;
    await(3, 50);
    rready <= 1'b0;
  endtask

  // Watcher: each completed response is matched with the oldest note
  always @(posedge clk_in) begin
    note_t q;
    if ((bvalid && bready) || (rvalid && rready)) begin
      if (notes.size() == 0) begin
        chk("note queue", 32'h1, 32'h0);
      end else begin
        q = notes.pop_front();
        chk(q.name, {30'h0, q.resp}, {30'h0, (bvalid && bready) ? bresp : rresp});
        chk(q.name, q.data & q.mask, (bvalid && bready) ? 32'h0 : rdata & q.mask);
      end
    end
  end

  initial begin
    {nrst_in, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {group_pin, close_pin, trip_pin, fault_pin, coil_open, prot_trip, leds} = '0;
    err_total = 0;
    checks = 0;
    rnd = $urandom(15320);
    cyc(2);
    nrst_in <= 1'b1;
    cyc(4);
    // Reset values, unmapped place, read-only status and byte lanes
    rd(OFF_CTRL, {28'h0, CTRL_RST}, 32'hffffffff, RESP_OKAY, "ctrl");
    rd(OFF_DELAY, {16'h0, DELAY_RST}, 32'hffffffff, RESP_OKAY, "delay");
    rd(OFF_IRQ_MASK, 32'h0, 32'hffffffff, RESP_OKAY, "mask");
    rd(OFF_STATUS, 32'h1010, 32'h1f1f, RESP_OKAY, "status");
    rd(8'h14, 32'h0, 32'hffffffff, RESP_SLVERR, "unmapped");
    wr(8'h14, 32'hffffffff, 4'hf, RESP_SLVERR);
    wr(OFF_STATUS, 32'hffffffff, 4'hf, RESP_OKAY);
    rnd = $urandom();
    wr(OFF_DELAY, rnd, 4'h1, RESP_OKAY);
    rd(OFF_DELAY, {16'h0, DELAY_RST[15:8], rnd[7:0]}, 32'hffffffff, RESP_OKAY, "delay lane");
    wr(OFF_IRQ_MASK, 32'h1f, 4'hf, RESP_OKAY);
    // Group select needs mapping in both groups
    group_pin <= 1'b1;
    cyc(6);
    chk("group unmapped", 32'h0, {31'h0, group_o});
    wr(OFF_CTRL, 32'h6, 4'hf, RESP_OKAY);
    cyc(3);
    chk("group high", 32'h1, {31'h0, group_o});
    rd(OFF_IRQ_STAT, 32'h10, 32'h10, RESP_OKAY, "group event");
    group_pin <= 1'b0;
    cyc(6);
    chk("group low", 32'h0, {31'h0, group_o});
    wr(OFF_CTRL, 32'h2, 4'hf, RESP_OKAY);
    group_pin <= 1'b1;
    cyc(6);
    chk("group one map", 32'h0, {31'h0, group_o});
    group_pin <= 1'b0;
    wr(OFF_IRQ_STAT, 32'h1f, 4'hf, RESP_OKAY);
    cyc(1);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    // Accepted close, fault-onto pulse, interrupt mask and clear
    close_pin <= 1'b1;
    await(4, 10);
    chk("close latency", 32'h4, waited);
    chk("close out", 32'h1, {31'h0, close_o});
    chk("irq close", 32'h1, {31'h0, irq_o});
    cyc(1);
    chk("onto pulse", 32'h0, {31'h0, onto_o});
    wr(OFF_IRQ_MASK, 32'h0, 4'hf, RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wr(OFF_IRQ_MASK, 32'h1f, 4'hf, RESP_OKAY);
    rd(OFF_IRQ_STAT, 32'h1, 32'h1f, RESP_OKAY, "close event");
    wr(OFF_IRQ_STAT, 32'h1, 4'hf, RESP_OKAY);
    close_pin <= 1'b0;
    cyc(5);
    chk("close drop", 32'h0, {31'h0, close_o});
    // Close blocked by latched indicators
    leds <= 1'b1;
    close_pin <= 1'b1;
    cyc(6);
    chk("close leds", 32'h0, {31'h0, close_o});
    rd(OFF_IRQ_STAT, 32'h2, 32'h3, RESP_OKAY, "blocked event");
    close_pin <= 1'b0;
    // Let the request leave the synchroniser before the block condition goes
    cyc(4);
    leds <= 1'b0;
    // External breaker fault blocks only when mapped
    wr(OFF_CTRL, 32'h8, 4'hf, RESP_OKAY);
    fault_pin <= 1'b1;
    close_pin <= 1'b1;
    cyc(6);
    chk("close fault", 32'h0, {31'h0, close_o});
    close_pin <= 1'b0;
    cyc(4);
    wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
    close_pin <= 1'b1;
    cyc(6);
    chk("close fault off", 32'h1, {31'h0, close_o});
    close_pin <= 1'b0;
    fault_pin <= 1'b0;
    // Manual trip, supervision paused meanwhile
    trip_pin <= 1'b1;
    cyc(4);
    chk("trip out", 32'h1, {31'h0, trip_o});
    rd(OFF_STATUS, 32'h4, 32'h14, RESP_OKAY, "status trip");
    trip_pin <= 1'b0;
    cyc(4);
    chk("trip drop", 32'h0, {31'h0, trip_o});
    wr(OFF_IRQ_STAT, 32'h1f, 4'hf, RESP_OKAY);
    // Supervision with breaker open, then closed
    for (p = 0; p < 2; p++) begin
      if (p == 1) begin
        close_pin <= 1'b1;
        cyc(5);
        close_pin <= 1'b0;
        cyc(5);
        chk("breaker closed", 32'h1, {31'h0, closed});
      end
      n = 1 + ($urandom() % 3);
      wr(OFF_DELAY, n, 4'hf, RESP_OKAY);
      coil_open <= 1'b1;
      cyc(30);
      chk("alarm disabled", 32'h0, {31'h0, alarm_o});
      wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
      coil_open <= 1'b0;
      wr(OFF_CTRL, 32'h1, 4'hf, RESP_OKAY);
      cyc(4);
      coil_open <= 1'b1;
      await(5, n * TK + 8);
      chk("alarm early", 32'h1, {31'h0, waited > n * TK});
      rd(OFF_IRQ_STAT, 32'h8, 32'h8, RESP_OKAY, "alarm event");
      if (p == 0) begin
        prot_trip <= 1'b1;
        cyc(3);
        chk("alarm in trip", 32'h0, {31'h0, alarm_o});
        prot_trip <= 1'b0;
      end else begin
        wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
        cyc(3);
        chk("alarm disable", 32'h0, {31'h0, alarm_o});
      end
      coil_open <= 1'b0;
      wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
    end
    cyc(5);
    close_out();
  end

  // Hang guard
  initial begin
    #2000000;
    err_total++;
    close_out();
  end
endmodule // relay_logic_input_functions_bench

`default_nettype wire
